// File: design/pmx_push_exec.sv
// Execution unit for the multi-register push in address-word and word forms.
`timescale 1ns/1ps
`include "pmx_defs.svh"
module pmx_push_exec #(
   parameter int unsigned MAX_COUNT = `PMX_NUM_REGS
) (
   input  wire logic                   clk_in,
   input  wire logic                   reset_n_in,
   input  wire logic                   start_in,
   input  wire logic                   push_multi_addr_word_in,
   input  wire logic [4:0]             count_in,
   input  wire logic [3:0]             dest_reg_in,
   input  wire logic [19:0]            stack_pointer_reg_in,
   input  wire logic [19:0]            reg_rdata_in,
   input  wire logic                   mem_ready_in,
   output logic                        busy_out,
   output logic                        done_out,
   output logic                        error_out,
   output logic [3:0]                  reg_raddr_out,
   output logic                        mem_wr_out,
   output logic [19:0]                 mem_addr_out,
   output logic [19:0]                 mem_wdata_out,
   output logic                        mem_aword_out,
   output logic                        sp_wr_out,
   output logic [19:0]                 stack_pointer_reg_out
);
   import pmx_pkg::*;

   localparam logic [4:0] COUNT_MAX = 5'(MAX_COUNT);

   pmx_state_t  state;
   logic        aword;
   logic [4:0]  left;
   logic [19:0] sp;
   logic        start_take;
   logic        start_legal;
   logic        slot_issue;
   logic        slot_accept;

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   // The register index is four bits wide, so a larger count would store
   // a register that was already stored in the same push.
   if (MAX_COUNT < 1 || MAX_COUNT > `PMX_NUM_REGS) begin : g_bad_count_limit
      $error("MAX_COUNT must lie between one and the register file size.");
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [19:0] pmx_step(input logic aw);
      pmx_step = aw ? `PMX_STEP_AWORD : `PMX_STEP_WORD;
   endfunction : pmx_step

   // A zero count would wrap the remaining count and store thirty-two slots, so it is refused too.
   function automatic logic pmx_count_ok(input logic [4:0] n);
      pmx_count_ok = (n != 5'h00) && (n <= COUNT_MAX);
   endfunction : pmx_count_ok

   // ---------------------------------------------------------------
   // Control strobes
   // ---------------------------------------------------------------
   // Start is only looked at in idle, so a start during a push is ignored.
   assign start_take  = (state == PMX_IDLE) && start_in;
   assign start_legal = pmx_count_ok(count_in);
   assign slot_issue  = (state == PMX_STORE) && !mem_wr_out;
   assign slot_accept = (state == PMX_STORE) && mem_wr_out && mem_ready_in;

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   // The form comes from the opcode flag alone; no prefix state exists.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state <= PMX_IDLE;
      end else begin
         case (state)
            PMX_IDLE: begin
               // Counts outside one to sixteen are refused without any write.
               if (start_take && start_legal) begin
                  state <= PMX_STORE;
               end
            end
            PMX_STORE: begin
               if (slot_accept && left == 5'h01) begin
                  state <= PMX_DONE;
               end
            end
            PMX_DONE: begin
               state <= PMX_IDLE;
            end
            default: begin
               state <= PMX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         aword <= 1'b0;
         left  <= 5'h00;
         sp    <= `PMX_SP_RESET;
      end else if (start_take && start_legal) begin
         aword <= push_multi_addr_word_in;
         left  <= count_in;
         sp    <= stack_pointer_reg_in;
      end else if (slot_issue) begin
         sp <= sp - pmx_step(aword);
      end else if (slot_accept) begin
         left <= left - 5'h01;
      end
   end

   // ---------------------------------------------------------------
   // Register read index
   // ---------------------------------------------------------------
   // The index wraps below zero when the count exceeds the named register.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         reg_raddr_out <= 4'h0;
      end else if (start_take && start_legal) begin
         reg_raddr_out <= dest_reg_in;
      end else if (slot_accept) begin
         // Walk downward from the named register.
         reg_raddr_out <= reg_raddr_out - 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // Stack writes
   // ---------------------------------------------------------------
   // Only memory writes are issued here; status bits and the stack pointer are written by the blocks below.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         mem_wr_out    <= 1'b0;
         mem_addr_out  <= 20'h00000;
         mem_wdata_out <= 20'h00000;
         mem_aword_out <= 1'b0;
      end else if (slot_issue) begin
         // Each slot sits one step below the previous one.
         mem_wr_out    <= 1'b1;
         mem_aword_out <= aword;
         mem_addr_out  <= sp - pmx_step(aword);
         // Full 20 bits in address-word form, low 16 bits otherwise.
         mem_wdata_out <= aword ? reg_rdata_in
                                : {4'h0, reg_rdata_in[`PMX_WORD_W-1:0]};
      end else if (slot_accept) begin
         // Request, address and data stand until the memory takes them.
         mem_wr_out <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Status
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         busy_out  <= 1'b0;
         done_out  <= 1'b0;
         error_out <= 1'b0;
      end else begin
         done_out  <= (start_take && !start_legal) || (state == PMX_DONE);
         error_out <= start_take && !start_legal;
         if (start_take && start_legal) begin
            busy_out <= 1'b1;
         end else if (state == PMX_DONE) begin
            busy_out <= 1'b0;
         end
      end
   end

   // The pointer is handed back once, after the last slot, so a stalled
   // push never exposes a half-lowered value.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sp_wr_out             <= 1'b0;
         stack_pointer_reg_out <= `PMX_SP_RESET;
      end else begin
         sp_wr_out <= (state == PMX_DONE);
         if (state == PMX_DONE) begin
            stack_pointer_reg_out <= sp;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Operands are captured apart from the working pointer, so the final
   // pointer is judged against count times step as well as the last slot address.
   logic [19:0] chk_sp0;
   logic [19:0] chk_span;
   logic [4:0]  chk_n;
   logic [4:0]  chk_writes;
   logic        chk_aw;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         chk_sp0    <= 20'h00000;
         chk_span   <= 20'h00000;
         chk_n      <= 5'h00;
         chk_writes <= 5'h00;
         chk_aw     <= 1'b0;
      end else if (start_take && start_legal) begin
         chk_sp0    <= stack_pointer_reg_in;
         chk_span   <= push_multi_addr_word_in ? {13'h0000, count_in, 2'h0}
                                               : {14'h0000, count_in, 1'h0};
         chk_n      <= count_in;
         chk_writes <= 5'h00;
         chk_aw     <= push_multi_addr_word_in;
      end else if (slot_accept) begin
         chk_writes <= chk_writes + 5'h01;
      end
   end

   property p_bad_count;
      @(posedge clk_in) disable iff (!reset_n_in)
      (state == PMX_IDLE && start_in && (count_in == 5'h00 || count_in > 5'h10))
         |=> (error_out && done_out && !busy_out);
   endproperty
   a_bad_count: assert property (p_bad_count) else $error("Bad count not refused.");

   property p_word_high_zero;
      @(posedge clk_in) disable iff (!reset_n_in)
      (mem_wr_out && !mem_aword_out) |-> (mem_wdata_out[19:16] == 4'h0);
   endproperty
   a_word_high_zero: assert property (p_word_high_zero) else $error("Word data too wide.");

   property p_aword_data;
      @(posedge clk_in) disable iff (!reset_n_in)
      $rose(mem_wr_out) && mem_aword_out |-> mem_wdata_out == $past(reg_rdata_in);
   endproperty
   a_aword_data: assert property (p_aword_data) else $error("Address-word data wrong.");

   property p_descend;
      @(posedge clk_in) disable iff (!reset_n_in)
      (state == PMX_STORE && mem_wr_out && mem_ready_in && left > 5'h01)
         |=> reg_raddr_out == $past(reg_raddr_out) - 4'h1;
   endproperty
   a_descend: assert property (p_descend) else $error("Register order wrong.");

   property p_slot_step;
      @(posedge clk_in) disable iff (!reset_n_in)
      $rose(mem_wr_out) |-> mem_addr_out == $past(sp) - (mem_aword_out ? 20'h00004 : 20'h00002);
   endproperty
   a_slot_step: assert property (p_slot_step) else $error("Stack slot step wrong.");

   property p_final_sp;
      @(posedge clk_in) disable iff (!reset_n_in)
      sp_wr_out |-> (stack_pointer_reg_out == mem_addr_out)
         && (stack_pointer_reg_out == chk_sp0 - chk_span);
   endproperty
   a_final_sp: assert property (p_final_sp) else $error("Final stack pointer wrong.");

   property p_one_word_two_step;
      @(posedge clk_in) disable iff (!reset_n_in)
      (sp_wr_out && !chk_aw && chk_n == 5'h01)
         |-> stack_pointer_reg_out == chk_sp0 - 20'h00002;
   endproperty
   a_one_word_two_step: assert property (p_one_word_two_step) else $error("Word step wrong.");

   property p_no_write_idle;
      @(posedge clk_in) disable iff (!reset_n_in)
      (state == PMX_IDLE) |-> !mem_wr_out;
   endproperty
   a_no_write_idle: assert property (p_no_write_idle) else $error("Write outside push.");

   property p_good_count;
      @(posedge clk_in) disable iff (!reset_n_in)
      (state == PMX_IDLE && start_in && count_in != 5'h00 && count_in <= 5'h10)
         |=> (busy_out && !error_out && !done_out);
   endproperty
   a_good_count: assert property (p_good_count) else $error("Legal count refused.");

   property p_form_held;
      @(posedge clk_in) disable iff (!reset_n_in)
      mem_wr_out |-> mem_aword_out == chk_aw;
   endproperty
   a_form_held: assert property (p_form_held) else $error("Write form changed.");

   property p_write_count;
      @(posedge clk_in) disable iff (!reset_n_in)
      sp_wr_out |-> chk_writes == chk_n;
   endproperty
   a_write_count: assert property (p_write_count) else $error("Write count wrong.");

   c_aword: cover property (@(posedge clk_in) sp_wr_out && mem_aword_out);
   c_word: cover property (@(posedge clk_in) sp_wr_out && !mem_aword_out);
   c_error: cover property (@(posedge clk_in) error_out);
   c_stall: cover property (@(posedge clk_in) mem_wr_out && !mem_ready_in);
   c_wrap: cover property (@(posedge clk_in) slot_accept && reg_raddr_out == 4'h0 && left > 5'h01);
endmodule : pmx_push_exec

// File: design/pmx_defs.svh
// Constants for the multi-register push execution unit.
// Notes on behaviour
// - Register count from one through sixteen accepted.
// - Address-word form stores full 20-bit registers.
// - Word form stores one 16-bit word each.
// - Store from named register down to lower ones.
// - Address-word form lowers stack pointer four per register.
// - Word form lowers stack pointer two per register.
// - Pushed registers keep bits 19:0 unchanged.
// - Opcode alone selects form, no extension word.
`ifndef PMX_DEFS_SVH
`define PMX_DEFS_SVH
`define PMX_NUM_REGS      16
`define PMX_ADDR_W        20
`define PMX_WORD_W        16
`define PMX_STEP_AWORD    20'h00004
`define PMX_STEP_WORD     20'h00002
`define PMX_SP_RESET      20'h00000
`endif

// File: design/pmx_pkg.sv
// Types for the multi-register push execution unit.
package pmx_pkg;
   typedef enum logic [1:0] {
      PMX_IDLE  = 2'b00,
      PMX_STORE = 2'b01,
      PMX_DONE  = 2'b10
   } pmx_state_t;
endpackage : pmx_pkg

// File: verification/pmx_mem_model.sv
// Stack memory model that accepts writes promptly or after a stall.
`timescale 1ns/1ps
module pmx_mem_model (
   input  wire logic clk_in,
   input  wire logic reset_n_in,
   input  wire logic mem_wr_in,
   input  wire logic slow_in,
   output logic      mem_ready_out
);
   logic [1:0] wait_cnt;
   // Ready is registered, so even a prompt answer costs the writer one cycle.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wait_cnt      <= 2'h0;
         mem_ready_out <= 1'b0;
      end else if (mem_wr_in && !mem_ready_out) begin
         if (!slow_in || wait_cnt == 2'h2) begin
            mem_ready_out <= 1'b1;
            wait_cnt      <= 2'h0;
         end else begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end else begin
         mem_ready_out <= 1'b0;
      end
   end
endmodule : pmx_mem_model

// File: verification/tb.sv
// Self-checking testbench for the multi-register push execution unit.
`timescale 1ns/1ps
module tb;
   logic        clk_in, reset_n_in, start_in, push_multi_addr_word_in, slow, mem_ready_in;
   logic [4:0]  count_in;
   logic [3:0]  dest_reg_in, reg_raddr_out;
   logic [19:0] stack_pointer_reg_in, reg_rdata_in, mem_addr_out, mem_wdata_out;
   logic [19:0] stack_pointer_reg_out;
   logic        busy_out, done_out, error_out, mem_wr_out, mem_aword_out, sp_wr_out;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   // Upper nibble is the register index, nonzero for all but register 0, so a word-form store must visibly drop it.
   assign reg_rdata_in = {reg_raddr_out, 12'h3C5, ~reg_raddr_out};
   pmx_push_exec i_dut (.clk_in, .reset_n_in, .start_in, .push_multi_addr_word_in,
      .count_in, .dest_reg_in, .stack_pointer_reg_in, .reg_rdata_in, .mem_ready_in,
      .busy_out, .done_out, .error_out, .reg_raddr_out, .mem_wr_out, .mem_addr_out,
      .mem_wdata_out, .mem_aword_out, .sp_wr_out, .stack_pointer_reg_out);
   pmx_mem_model i_mem (.clk_in, .reset_n_in, .mem_wr_in(mem_wr_out), .slow_in(slow),
      .mem_ready_out(mem_ready_in));
   task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic run_push(input logic a, input logic [4:0] n, input logic [3:0] d,
                           input logic [19:0] sp, input logic s);
      logic [19:0] step;
      logic [3:0]  r;
      logic        legal;
      int          k;
      step  = a ? 20'h00004 : 20'h00002;
      r     = d;
      legal = (n != 5'h00) && (n <= 5'h10);
      k     = 0;
      @(posedge clk_in);
      start_in                <= 1'b1;
      push_multi_addr_word_in <= a;
      count_in                <= n;
      dest_reg_in             <= d;
      stack_pointer_reg_in    <= sp;
      slow                    <= s;
      @(posedge clk_in);
      start_in <= 1'b0;
      do begin
         @(negedge clk_in);
         if (mem_wr_out && mem_ready_in) begin
            k++;
            chk({19'h0, busy_out}, 20'h00001, "busy in push");
            chk(mem_addr_out, sp - step * 20'(k), "slot address");
            chk(mem_wdata_out, {a ? r : 4'h0, 12'h3C5, ~r}, "slot data");
            chk({19'h0, mem_aword_out}, {19'h0, a}, "slot width");
            r = r - 4'h1;
         end
      end while (!done_out);
      chk({19'h0, busy_out}, 20'h00000, "busy after end");
      chk({19'h0, error_out}, {19'h0, !legal}, "error flag");
      chk(20'(k), legal ? 20'(n) : 20'h0, "write count");
      chk({19'h0, sp_wr_out}, {19'h0, legal}, "sp write");
      if (legal) begin
         chk(stack_pointer_reg_out, sp - step * 20'(n), "final sp");
      end
   endtask : run_push
   task automatic t_aword_prompt;
      run_push(1'b1, 5'h05, 4'hD, 20'h0A000, 1'b0);
   endtask : t_aword_prompt
   task automatic t_word_stall;
      run_push(1'b0, 5'h05, 4'hD, 20'h0A000, 1'b1);
   endtask : t_word_stall
   task automatic t_aword_full_stall;
      run_push(1'b1, 5'h10, 4'hF, 20'h10000, 1'b1);
   endtask : t_aword_full_stall
   task automatic t_word_single;
      run_push(1'b0, 5'h01, 4'h0, 20'h00400, 1'b0);
   endtask : t_word_single
   task automatic t_word_wrap;
      run_push(1'b0, 5'h10, 4'h3, 20'h00402, 1'b0);
   endtask : t_word_wrap
   task automatic t_zero_count;
      run_push(1'b1, 5'h00, 4'h7, 20'h0A000, 1'b0);
   endtask : t_zero_count
   task automatic t_over_count;
      run_push(1'b0, 5'h11, 4'h7, 20'h0A000, 1'b0);
   endtask : t_over_count
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   // The ceiling is far above the longest run so only a hang reaches it.
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         $display("[ERR] %0t timeout", $time);
         end_sim();
      end
   end
   initial begin
      reset_n_in              = 1'b0;
      start_in                = 1'b0;
      push_multi_addr_word_in = 1'b0;
      count_in                = 5'h00;
      dest_reg_in             = 4'h0;
      stack_pointer_reg_in    = 20'h00000;
      slow                    = 1'b0;
      repeat (12) @(posedge clk_in);
      reset_n_in <= 1'b1;
      t_aword_prompt();
      t_word_stall();
      t_aword_full_stall();
      t_word_single();
      t_word_wrap();
      t_zero_count();
      t_over_count();
      end_sim();
   end
endmodule : tb
